// file: sbm_consts.vh
// Constants for the SPI bus monitor and trigger block
`ifndef SBM_CONSTS_VH
`define SBM_CONSTS_VH
// Trigger mode encodings
`define SBM_TRIG_FSTART 2'h0
`define SBM_TRIG_FEND 2'h1
`define SBM_TRIG_BIT 2'h2
`define SBM_TRIG_PATT 2'h3
// Word size limits
`define SBM_WORD_MAX 32
`define SBM_WCNT_W 6
// Default idle time in ns and sampling period in ns
`define SBM_IDLE_NS 1000
`define SBM_CLK_NS 10
`define SBM_IDLE_CYC ((`SBM_IDLE_NS) / (`SBM_CLK_NS))
// Polarity reset values: 1 means high active
`define SBM_CS_POL_RST 1'b0
`define SBM_DATA_POL_RST 1'b1
// Field width of bit counters
`define SBM_BCNT_W 16
`endif

// file: sbm_sync.v
// Two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/100ps
module sbm_sync (
	input wire clk_sys,
	input wire reset_n,
	input wire din,
	output reg dout,
	output wire rise,
	output wire fall
);
	reg meta_q;
	reg sync_q;

	// ----------------------------------------
	// Synchroniser and history
	// ----------------------------------------
	// The first flop feeds only the second one, never any logic
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_q <= din;
			sync_q <= meta_q;
			dout <= sync_q;
		end
	end

	// Edges compare the settled level with its previous value
	assign rise = sync_q & ~dout;
	assign fall = ~sync_q & dout;
endmodule

// file: sbm_idle.v
// Idle timer measuring quiet time since the last bus clock edge
`timescale 1ns/100ps
module sbm_idle #(
	parameter CNT_W = 24
) (
	input wire clk_sys,
	input wire reset_n,
	input wire edge_seen,
	input wire [CNT_W-1:0] limit,
	output reg expired
);
	reg [CNT_W-1:0] cnt_q;

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// Restarts on every bus clock edge; saturates at the limit
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			cnt_q <= {CNT_W{1'b0}};
			expired <= 1'b1;
		end else if (edge_seen) begin
			cnt_q <= {CNT_W{1'b0}}; // R22
			expired <= 1'b0;
		end else if (cnt_q < limit) begin
			cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // R22
			expired <= 1'b0;
		end else begin
			expired <= 1'b1;
		end
	end
endmodule

// file: sbm_monitor.v
// Passive SPI bus monitor: word and frame assembly plus trigger events
// Operation
// R1: Bits form words; frames hold words
// R2: Word length selectable up to 32
// R3: Bit order selects MSB or LSB first
// R4: Chosen clock edge starts each bit
// R5: Each line has own polarity setting
// R6: Reset: chip select low active, data high
// R7: CS mode: frame starts on CS active
// R8: CS mode: frame ends on CS inactive
// R9: No-CS mode: frame starts after idle time
// R10: Short gaps keep words in one frame
// R11: No-CS: frame ends after idle elapses
// R12: Trigger mode picks exactly one condition
// R13: Bits numbered from one; offset skips bits
// R14: Bit trigger fires on bit after offset
// R15: Source selects MOSI or MISO for trigger
// R16: MOSI required, MISO optional
// R17: Second data line only on instances one, three
// R18: Master drives clock and select, no ack
// R19: Pattern trigger marks pattern first bit; trig_q pulses at the last pattern bit
// R20: Pattern bits zero, one or don't-care
// R21: Report word count, start time, words
// R22: Idle counted in sampling clocks, restart
// R23: Only pattern-length bits are compared
`timescale 1ns/100ps
`include "sbm_consts.vh"
module sbm_monitor #(
	parameter INSTANCE = 1,
	parameter IDLE_CYC = `SBM_IDLE_CYC,
	parameter TIME_W = 32,
	parameter CNT_W = 24
) (
	input wire clk_sys,
	input wire reset_n,
	input wire spi_sclk,
	input wire spi_cs,
	input wire spi_mosi,
	input wire spi_miso,
	input wire cfg_use_cs,
	input wire cfg_miso_en,
	input wire cfg_falling,
	input wire cfg_lsb_first,
	input wire [5:0] cfg_word_len,
	input wire cfg_pol_wr,
	input wire cfg_cs_pol,
	input wire cfg_mosi_pol,
	input wire cfg_miso_pol,
	input wire [CNT_W-1:0] cfg_idle,
	input wire [1:0] cfg_trig_mode,
	input wire cfg_trig_miso,
	input wire [15:0] cfg_offset,
	input wire [5:0] cfg_patt_len,
	input wire [31:0] cfg_patt_val,
	input wire [31:0] cfg_patt_care,
	output reg trig_q,
	output reg frame_start_q,
	output reg frame_end_q,
	output reg in_frame_q,
	output reg word_valid_q,
	output reg [31:0] mosi_word_q,
	output reg [31:0] miso_word_q,
	output reg frame_valid_q,
	output reg [15:0] frame_words_q,
	output reg [TIME_W-1:0] frame_time_q,
	output reg miso_avail_q
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	wire sclk_s, cs_s, mosi_s, miso_s;
	wire sclk_r, sclk_f, cs_r, cs_f;

	sbm_sync u_sclk (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.din(spi_sclk),
		.dout(sclk_s),
		.rise(sclk_r),
		.fall(sclk_f)
	);
	sbm_sync u_cs (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.din(spi_cs),
		.dout(cs_s),
		.rise(cs_r),
		.fall(cs_f)
	);
	sbm_sync u_mosi (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.din(spi_mosi),
		.dout(mosi_s),
		.rise(),
		.fall()
	);
	sbm_sync u_miso (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.din(spi_miso),
		.dout(miso_s),
		.rise(),
		.fall()
	);

	// ----------------------------------------
	// Polarity registers
	// ----------------------------------------
	reg cs_pol_q, mosi_pol_q, miso_pol_q;

	// Loaded by a write strobe so reset defaults are meaningful
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			cs_pol_q <= `SBM_CS_POL_RST; // R6
			mosi_pol_q <= `SBM_DATA_POL_RST; // R6
			miso_pol_q <= `SBM_DATA_POL_RST; // R6
		end else if (cfg_pol_wr) begin
			cs_pol_q <= cfg_cs_pol;
			mosi_pol_q <= cfg_mosi_pol;
			miso_pol_q <= cfg_miso_pol;
		end
	end

	// Logic values after polarity; pol 1 means high active
	wire mosi_bit = mosi_s ~^ mosi_pol_q; // R5
	wire miso_bit = miso_s ~^ miso_pol_q; // R5
	// Second line is only allowed on instances one and three
	wire miso_ok = cfg_miso_en && (INSTANCE == 1 || INSTANCE == 3); // R17 R16
	// Synchronised CS edges, seen as active and inactive transitions
	wire cs_act_e = cs_pol_q ? cs_r : cs_f;
	wire cs_inact_e = cs_pol_q ? cs_f : cs_r;
	wire cs_active = cs_s ~^ cs_pol_q;

	// Selected clock edge samples data and opens a bit
	wire bit_e = cfg_falling ? sclk_f : sclk_r; // R4
	// Any edge restarts the idle timer, whichever edge samples data
	wire any_e = sclk_r | sclk_f;

	// ----------------------------------------
	// Idle timer for mode without chip select
	// ----------------------------------------
	wire idle_exp;

	sbm_idle #(
		.CNT_W(CNT_W)
	) u_idle (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.edge_seen(any_e),
		.limit(cfg_idle),
		.expired(idle_exp)
	);

	// ----------------------------------------
	// Free running time stamp
	// ----------------------------------------
	reg [TIME_W-1:0] now_q;

	always @(posedge clk_sys) begin
		if (!reset_n)
			now_q <= {TIME_W{1'b0}};
		else
			now_q <= now_q + {{(TIME_W-1){1'b0}}, 1'b1};
	end

	// ----------------------------------------
	// Frame state
	// ----------------------------------------
	// Armed once the bus has been quiet for the idle time; it stays
	// armed until a frame opens, so in falling edge mode the rising
	// half of the first bit cannot disarm it before the bit is taken
	reg idle_exp_q;

	// In no-CS mode a frame opens at the first selected edge after idle
	wire nocs_start = !cfg_use_cs && !in_frame_q && bit_e && idle_exp_q;
	wire nocs_end = !cfg_use_cs && in_frame_q && idle_exp; // R11
	wire fr_start = cfg_use_cs ? cs_act_e : nocs_start; // R7 R9
	wire fr_end = cfg_use_cs ? (cs_inact_e && in_frame_q) : nocs_end; // R8
	// Bits count only inside a frame; CS mode also needs CS active
	wire bit_take = bit_e && (cfg_use_cs ? cs_active : 1'b1)
		&& (in_frame_q || fr_start);
	// Expiry sets the arm flag and wins over a frame start
	always @(posedge clk_sys) begin
		if (!reset_n)
			idle_exp_q <= 1'b1;
		else if (idle_exp)
			idle_exp_q <= 1'b1; // R9
		else if (fr_start)
			idle_exp_q <= 1'b0;
	end

	reg [5:0] bit_in_word_q;
	reg [31:0] mosi_sh_q, miso_sh_q;
	reg [15:0] bit_num_q;
	reg [15:0] words_q;
	reg [TIME_W-1:0] start_q;
	reg [5:0] wlen;
	reg last_bit;
	reg [31:0] mosi_next, miso_next;

	// Clamp word length into 1..32
	always @* begin
		wlen = cfg_word_len;
		if (cfg_word_len == 6'h00 || cfg_word_len > 6'h20)
			wlen = 6'h20; // R2
		last_bit = (bit_in_word_q + 6'h01) == wlen;
		// Shift direction per bit order; final word is right aligned
		if (cfg_lsb_first) begin
			mosi_next = {mosi_bit, mosi_sh_q[31:1]}; // R3
			miso_next = {miso_bit, miso_sh_q[31:1]};
		end else begin
			mosi_next = {mosi_sh_q[30:0], mosi_bit}; // R3
			miso_next = {miso_sh_q[30:0], miso_bit};
		end
	end

	// Word assembly, frame bookkeeping and reporting
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			in_frame_q <= 1'b0;
			bit_in_word_q <= 6'h00;
			mosi_sh_q <= 32'h0000_0000;
			miso_sh_q <= 32'h0000_0000;
			bit_num_q <= 16'h0000;
			words_q <= 16'h0000;
			start_q <= {TIME_W{1'b0}};
			word_valid_q <= 1'b0;
			mosi_word_q <= 32'h0000_0000;
			miso_word_q <= 32'h0000_0000;
			frame_valid_q <= 1'b0;
			frame_words_q <= 16'h0000;
			frame_time_q <= {TIME_W{1'b0}};
			frame_start_q <= 1'b0;
			frame_end_q <= 1'b0;
			miso_avail_q <= 1'b0;
		end else begin
			word_valid_q <= 1'b0;
			frame_valid_q <= 1'b0;
			frame_start_q <= fr_start;
			frame_end_q <= fr_end;
			miso_avail_q <= miso_ok;
			if (fr_start) begin
				in_frame_q <= 1'b1;
				bit_in_word_q <= 6'h00;
				bit_num_q <= 16'h0000;
				words_q <= 16'h0000;
				start_q <= now_q; // R21
			end else if (fr_end) begin
				in_frame_q <= 1'b0;
				// Report only frames that held at least one word
				frame_valid_q <= words_q != 16'h0000; // R1 R21
				frame_words_q <= words_q; // R21
				frame_time_q <= start_q; // R21
			end
			if (bit_take && !fr_end) begin
				bit_num_q <= (fr_start ? 16'h0000 : bit_num_q) + 16'h0001;
				if (last_bit) begin
					// Right align LSB-first words of short length
					mosi_word_q <= cfg_lsb_first ?
						(mosi_next >> (6'h20 - wlen)) : mosi_next; // R1
					miso_word_q <= !miso_ok ? 32'h0000_0000 :
						cfg_lsb_first ? (miso_next >> (6'h20 - wlen))
						: miso_next;
					word_valid_q <= 1'b1;
					bit_in_word_q <= 6'h00;
					words_q <= (fr_start ? 16'h0000 : words_q) + 16'h0001;
					mosi_sh_q <= 32'h0000_0000;
					miso_sh_q <= 32'h0000_0000;
				end else begin
					mosi_sh_q <= mosi_next;
					miso_sh_q <= miso_next;
					bit_in_word_q <= bit_in_word_q + 6'h01; // R10
				end
			end
		end
	end

	// ----------------------------------------
	// Trigger logic
	// ----------------------------------------
	// Source line for the trigger, MISO only when available
	wire trig_bit = (cfg_trig_miso && miso_ok) ? miso_bit : mosi_bit; // R15
	// Number this bit will carry, counted from one
	wire [15:0] cur_num = (fr_start ? 16'h0000 : bit_num_q) + 16'h0001;
	wire [15:0] patt_first = cfg_offset + 16'h0001; // R13
	// Last bit number that still takes part in the pattern
	wire [15:0] patt_last = cfg_offset + {10'h000, cfg_patt_len};
	// Received pattern bits, cleared at every frame boundary
	reg [31:0] got_q;
	reg patt_busy_q;
	reg [TIME_W-1:0] patt_t_q;
	wire [5:0] pidx = cur_num[5:0] - patt_first[5:0];
	wire in_patt = bit_take && cfg_patt_len != 6'h00
		&& cur_num >= patt_first && cur_num <= patt_last; // R23
	wire [31:0] got_next = got_q | ({31'h0, trig_bit} << pidx);
	wire [31:0] len_mask = (cfg_patt_len >= 6'h20) ? 32'hFFFF_FFFF :
		((32'h0000_0001 << cfg_patt_len) - 32'h0000_0001);
	// Care bits select compared positions; don't-care matches both
	wire patt_hit = ((got_next ^ cfg_patt_val) & cfg_patt_care
		& len_mask) == 32'h0000_0000; // R20 R23

	// Pattern is captured as bit 0 = first pattern bit
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			got_q <= 32'h0000_0000;
			patt_busy_q <= 1'b0;
			patt_t_q <= {TIME_W{1'b0}};
		end else if (fr_start || fr_end) begin
			got_q <= 32'h0000_0000;
			patt_busy_q <= 1'b0;
		end else if (in_patt) begin
			got_q <= got_next;
			patt_busy_q <= cur_num != patt_last;
			if (cur_num == patt_first)
				patt_t_q <= now_q;
		end
	end

	// One pulse per selected condition; the pattern trigger is
	// only known at its last bit, so it is flagged then while
	// the first bit time is kept in patt_t_q, which reaches no output.
	always @(posedge clk_sys) begin
		if (!reset_n) begin
			trig_q <= 1'b0;
		end else begin
			case (cfg_trig_mode) // R12
			`SBM_TRIG_FSTART:
				trig_q <= fr_start;
			`SBM_TRIG_FEND:
				trig_q <= fr_end;
			`SBM_TRIG_BIT:
				trig_q <= bit_take && cur_num == patt_first; // R14
			`SBM_TRIG_PATT:
				trig_q <= in_patt && cur_num == patt_last
					&& patt_hit; // R19
			default:
				trig_q <= 1'b0;
			endcase
		end
	end
endmodule

// file: sbm_spi_dev.sv
// Behavioural model of the observed SPI master and slave pair
`timescale 1ns/100ps
module sbm_spi_dev (
	output logic spi_sclk,
	output logic spi_cs,
	output logic spi_mosi,
	output logic spi_miso
);
	// ---------------
	// Bus state
	// ---------------
	localparam real HALF = 62.5;
	// Idle bus: clock parked low, select inactive for a low active select
	initial begin
		spi_sclk = 1'b0;
		spi_cs = 1'b1;
		spi_mosi = 1'b0;
		spi_miso = 1'b1;
	end
	// Data moves mid low phase so both clock edges see a settled bit
	task automatic xfer(input logic act, input int n,
			input logic [31:0] mo, mi);
		spi_cs = act;
		#HALF;
		for (int i = n - 1; i >= 0; i--) begin
			#(HALF / 2);
			spi_mosi = mo[i];
			spi_miso = mi[i];
			#(HALF / 2) spi_sclk = 1'b1;
			#HALF spi_sclk = 1'b0;
		end
		#HALF spi_cs = ~act;
		// Released lines flip so a stale level never passes as data
		spi_mosi = ~spi_mosi;
		spi_miso = ~spi_miso;
	endtask
endmodule

// file: sbm_chk_monitor.sv
// Concurrent checks on the SPI bus monitor ports
`timescale 1ns/100ps
`include "sbm_consts.vh"
module sbm_chk #(
	parameter INSTANCE = 1
) (
	input wire clk_sys,
	input wire reset_n,
	input wire cfg_use_cs,
	input wire cfg_miso_en,
	input wire [1:0] cfg_trig_mode,
	input wire trig_q,
	input wire frame_start_q,
	input wire frame_end_q,
	input wire in_frame_q,
	input wire word_valid_q,
	input wire frame_valid_q,
	input wire miso_avail_q
);
	// ------------------------------
	// Framing, trigger and data line properties
	// ------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// An end that a new start in the same cycle does not overtake
	sequence s_end_only;
		frame_end_q && !frame_start_q;
	endsequence
	property p_start_enter;
		frame_start_q |=> in_frame_q;
	endproperty
	a_start_enter: assert property (p_start_enter)
		else $error("frame start did not enter a frame");
	property p_end_leave;
		s_end_only |=> !in_frame_q;
	endproperty
	a_end_leave: assert property (p_end_leave)
		else $error("frame end did not leave the frame");
	property p_trig_pulse;
		trig_q |=> !trig_q;
	endproperty
	a_trig_pulse: assert property (p_trig_pulse)
		else $error("trigger longer than one cycle");
	property p_word_in;
		word_valid_q |-> in_frame_q;
	endproperty
	a_word_in: assert property (p_word_in)
		else $error("word completed outside a frame");
	property p_report;
		cfg_use_cs ##0 s_end_only |-> ##[0:2] frame_valid_q;
	endproperty
	a_report: assert property (p_report)
		else $error("no frame report after frame end");
	property p_trig_start;
		cfg_trig_mode == `SBM_TRIG_FSTART && frame_start_q |-> ##[0:2] trig_q;
	endproperty
	a_trig_start: assert property (p_trig_start)
		else $error("no trigger on frame start");
	property p_trig_end;
		cfg_trig_mode == `SBM_TRIG_FEND && frame_end_q |-> ##[0:2] trig_q;
	endproperty
	a_trig_end: assert property (p_trig_end)
		else $error("no trigger on frame end");
	property p_miso;
		cfg_miso_en [*3] |-> miso_avail_q == (INSTANCE == 1 || INSTANCE == 3);
	endproperty
	a_miso: assert property (p_miso)
		else $error("second data line availability wrong");
endmodule

// file: testbench.sv
// Self-checking testbench for the SPI bus monitor and trigger block
`timescale 1ns/100ps
`include "sbm_consts.vh"
module testbench;
	logic clk_sys, reset_n, spi_sclk, spi_cs, spi_mosi, spi_miso;
	logic cfg_use_cs, cfg_miso_en, cfg_falling, cfg_lsb_first, cfg_pol_wr;
	logic cfg_cs_pol, cfg_mosi_pol, cfg_miso_pol, cfg_trig_miso;
	logic [5:0] cfg_word_len, cfg_patt_len;
	logic [23:0] cfg_idle;
	logic [1:0] cfg_trig_mode;
	logic [15:0] cfg_offset, frame_words_q, fw;
	logic [31:0] cfg_patt_val, cfg_patt_care, mosi_word_q, miso_word_q;
	logic [31:0] frame_time_q;
	logic trig_q, frame_start_q, frame_end_q, in_frame_q, word_valid_q;
	logic frame_valid_q, miso_avail_q;
	logic [31:0] mo [8];
	logic [31:0] mi [8];
	logic [31:0] pv [3] = '{32'h1D, 32'h09, 32'h05};
	logic [31:0] pc [3] = '{32'hFF, 32'h0B, 32'h0F};
	int bad_count, checks, n_trig, n_fs, n_fe, n_w;
	int cyc, fs, fs0;
	logic [31:0] ft, ft0;
	// ---------------
	// Harness
	// ---------------
	sbm_monitor #(.INSTANCE(1)) dut (.clk_sys, .reset_n, .spi_sclk, .spi_cs,
		.spi_mosi, .spi_miso, .cfg_use_cs, .cfg_miso_en, .cfg_falling,
		.cfg_lsb_first, .cfg_word_len, .cfg_pol_wr, .cfg_cs_pol, .cfg_mosi_pol,
		.cfg_miso_pol, .cfg_idle, .cfg_trig_mode, .cfg_trig_miso, .cfg_offset,
		.cfg_patt_len, .cfg_patt_val, .cfg_patt_care, .trig_q, .frame_start_q,
		.frame_end_q, .in_frame_q, .word_valid_q, .mosi_word_q, .miso_word_q,
		.frame_valid_q, .frame_words_q, .frame_time_q, .miso_avail_q);
	sbm_spi_dev bus (.spi_sclk, .spi_cs, .spi_mosi, .spi_miso);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Tally pulses; pulses last one cycle so each edge counts once
	always @(posedge clk_sys) begin
		if (trig_q) n_trig <= n_trig + 1;
		if (frame_start_q) n_fs <= n_fs + 1;
		if (frame_end_q) n_fe <= n_fe + 1;
		cyc <= cyc + 1;
		// Start pulses and reported start stamps, last two of each
		if (frame_start_q) {fs0, fs} <= {fs, cyc};
		if (frame_valid_q) begin
			fw <= frame_words_q;
			{ft0, ft} <= {ft, frame_time_q};
		end
		if (word_valid_q) n_w <= n_w + 1;
		if (word_valid_q && n_w < 8) begin
			mo[n_w] <= mosi_word_q;
			mi[n_w] <= miso_word_q;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic setup(input logic cs, lsb, fall, input logic [5:0] wl,
			input logic [1:0] md, input logic [15:0] off);
		@(posedge clk_sys);
		cfg_use_cs <= cs;
		cfg_lsb_first <= lsb;
		cfg_falling <= fall;
		cfg_word_len <= wl;
		cfg_trig_mode <= md;
		cfg_offset <= off;
		// Long enough for the idle timer to expire before the next test
		repeat (60) @(posedge clk_sys);
		n_trig = 0;
		n_fs = 0;
		n_fe = 0;
		n_w = 0;
	endtask
	task automatic frame(input logic act, input int n,
			input logic [31:0] a, b, input int gap);
		bus.xfer(act, n, a, b);
		repeat (gap) @(posedge clk_sys);
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Whole run is near 20 us; a hang is cut well past that
	initial begin
		#500000;
		bad_count++;
		final_report();
	end
	initial begin
		{reset_n, cfg_use_cs, cfg_falling, cfg_lsb_first, cfg_pol_wr} = '0;
		{cfg_cs_pol, cfg_mosi_pol, cfg_miso_pol, cfg_trig_miso} = '0;
		{cfg_trig_mode, cfg_offset, cfg_patt_val} = '0;
		cfg_miso_en = 1'b1;
		cfg_word_len = 6'h08;
		cfg_patt_len = 6'h04;
		cfg_idle = 24'h000028;
		cfg_patt_care = 32'hFFFFFFFF;
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'b1;
		// Select framing with a trailing partial word, default polarity
		setup(1'b1, 1'b0, 1'b0, 6'h08, `SBM_TRIG_FSTART, 16'h0);
		frame(1'b0, 20, 32'hA53C7, 32'h5A0F1, 20);
		chk(n_fs, 32'h1);
		chk(n_fe, 32'h1);
		chk(n_trig, 32'h1);
		chk(mo[0], 32'hA5);
		chk(mo[1], 32'h3C);
		chk(mi[1], 32'h0F);
		chk(fw, 32'h2);
		$display("test select_frame done");
		// Widest word, reversed bit order, trigger at frame end
		setup(1'b1, 1'b1, 1'b0, 6'h20, `SBM_TRIG_FEND, 16'h0);
		frame(1'b0, 32, 32'h12345678, 32'h0, 20);
		chk(mo[0], 32'h1E6A2C48);
		chk(n_trig, 32'h1);
		$display("test long_word done");
		// Idle framing on falling edges, short gap keeps one frame
		setup(1'b0, 1'b0, 1'b1, 6'h08, `SBM_TRIG_BIT, 16'h4);
		frame(1'b0, 8, 32'h96, 32'h0, 2);
		frame(1'b0, 8, 32'h69, 32'h0, 60);
		chk(n_fs, 32'h1);
		chk(n_fe, 32'h1);
		chk(mo[1], 32'h69);
		chk(fw, 32'h2);
		chk(n_trig, 32'h1);
		frame(1'b0, 8, 32'h0F, 32'h0, 60);
		chk(n_fs, 32'h2);
		chk(ft - ft0, fs - fs0);
		$display("test idle_frame done");
		// Pattern on the slave line at offset two, table of cases
		setup(1'b1, 1'b0, 1'b0, 6'h08, `SBM_TRIG_PATT, 16'h2);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys);
			cfg_trig_miso <= 1'b1;
			cfg_patt_val <= pv[k];
			cfg_patt_care <= pc[k];
			@(posedge clk_sys);
			n_trig = 0;
			frame(1'b0, 8, 32'h00, 32'h2C, 20);
			chk(n_trig, {31'h0, k != 2});
		end
		$display("test pattern done");
		// Inverted data polarity on both data lines
		@(posedge clk_sys);
		cfg_pol_wr <= 1'b1;
		@(posedge clk_sys);
		cfg_pol_wr <= 1'b0;
		setup(1'b1, 1'b0, 1'b0, 6'h08, `SBM_TRIG_FSTART, 16'h0);
		frame(1'b0, 8, 32'hA5, 32'h0F, 20);
		chk(mo[0], 32'h5A);
		chk(mi[0], 32'hF0);
		$display("test polarity done");
		final_report();
	end
endmodule
bind sbm_monitor sbm_chk #(.INSTANCE(INSTANCE)) u_chk (.clk_sys, .reset_n,
	.cfg_use_cs, .cfg_miso_en, .cfg_trig_mode, .trig_q, .frame_start_q,
	.frame_end_q, .in_frame_q, .word_valid_q, .frame_valid_q, .miso_avail_q);
